// >>> dpdpb_pkg.sv
// constants, types and field layout of the dual patch domain payload builder
package dpdpb_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_SCRATCH     = 8'h04;
    localparam logic [7:0]  REG_BIND        = 8'h08;
    localparam logic [7:0]  REG_SAMPLER     = 8'h0C;
    localparam logic [7:0]  REG_STATUS      = 8'h10;
    localparam logic [7:0]  REG_THREADID    = 8'h14;

    localparam int          CTRL_WEN_BIT    = 0;
    localparam int          CTRL_OMIT_BIT   = 1;
    localparam int          SCR_OFF_LSB     = 10;
    localparam int          SCR_SIZE_W      = 4;
    localparam logic [3:0]  SCR_SIZE_MAX    = 4'hB;
    localparam int          PTR_LSB         = 5;
    localparam int          STAT_BUSY_BIT   = 16;

    localparam logic [1:0]  CTRL_RESET      = 2'h0;
    localparam logic [21:0] SCR_OFF_RESET   = 22'h0;
    localparam logic [3:0]  SCR_SIZE_RESET  = 4'h0;
    localparam logic [26:0] PTR_RESET       = 27'h0;

    // ----------------------------------------------------------------
    // thread identity
    // ----------------------------------------------------------------
    localparam int          TID_W           = 24;
    localparam int          TAG_W           = 10;
    localparam logic [10:0] TAG_LIMIT       = 11'h400;

    // ----------------------------------------------------------------
    // float constants
    // ----------------------------------------------------------------
    localparam logic [31:0] FP_ONE          = 32'h3F800000;
    localparam logic [31:0] FP_ZERO         = 32'h00000000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_HDR  = 3'h1,
        ST_PRIM = 3'h2,
        ST_UCRD = 3'h3,
        ST_VCRD = 3'h4,
        ST_WCRD = 3'h5
    } dpdpb_state_t;

    // lane 0..3 = patch 0 points 0..3, lane 4..7 = patch 1 points 0..3
    typedef struct packed {
        logic [15:0]       retBufOff1;
        logic [15:0]       retBufOff0;
        logic [31:0]       primId1;
        logic [31:0]       primId0;
        logic [7:0][31:0]  uCoord;
        logic [7:0][31:0]  vCoord;
    } dpdpb_req_t;

    typedef struct packed {
        logic              first;
        logic              last;
        logic [255:0]      data;
    } dpdpb_beat_t;

endpackage

// >>> dpdpb_fp_add.sv
// single precision adder, truncating, denormals flushed to zero
`timescale 1ns/1ps
module dpdpb_fp_add (
    input  wire logic [31:0] opA,
    input  wire logic [31:0] opB,
    output logic      [31:0] sum
);
    wire        aBig     = opA[30:0] >= opB[30:0];
    wire [31:0] big      = aBig ? opA : opB;
    wire [31:0] sml      = aBig ? opB : opA;
    wire        bigZero  = big[30:23] == 8'h00;
    wire        smlZero  = sml[30:23] == 8'h00;
    wire [7:0]  expDiff  = big[30:23] - sml[30:23];
    wire [26:0] manBig   = bigZero ? 27'h0 : {2'h1, big[22:0], 2'h0};
    wire [26:0] manSmlR  = smlZero ? 27'h0 : {2'h1, sml[22:0], 2'h0};
    wire [26:0] manSml   = (expDiff > 8'h1A) ? 27'h0 : (manSmlR >> expDiff);
    wire        doSub    = big[31] ^ sml[31];
    wire [26:0] manRaw   = doSub ? (manBig - manSml) : (manBig + manSml);

    logic [4:0]        shiftL;
    logic              found;
    logic [26:0]       manNorm;
    logic signed [9:0] expNorm;

    // truncation instead of round-to-nearest keeps this to one short path
    always_comb begin
        shiftL = 5'h0;
        found  = 1'b0;
        for (int i = 25; i >= 0; i--) begin
            if (!found && manRaw[i]) begin
                shiftL = 5'(25 - i);
                found  = 1'b1;
            end
        end
        if (manRaw[26]) begin
            manNorm = manRaw >> 1;
            expNorm = $signed({2'h0, big[30:23]}) + 10'sh001;
        end else begin
            manNorm = manRaw << shiftL;
            expNorm = $signed({2'h0, big[30:23]}) - $signed({5'h0, shiftL});
        end
        if (bigZero || manRaw == 27'h0) begin
            sum = 32'h00000000;
        end else if (expNorm <= 10'sh000) begin
            sum = {big[31], 31'h0};
        end else if (expNorm >= 10'sh0FF) begin
            sum = {big[31], 8'hFF, 23'h0};
        end else begin
            sum = {big[31], expNorm[7:0], manNorm[24:2]};
        end
    end
endmodule

// >>> dpdpb_builder.sv
// dual patch domain evaluation thread payload builder
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module dpdpb_builder (
    input  wire logic                     mclk,
    input  wire logic                     reset,
    input  wire logic [7:0]               regAddr,
    input  wire logic [31:0]              regWrData,
    input  wire logic                     regWrite,
    input  wire logic                     regRead,
    output logic      [31:0]              regRdData,
    input  wire logic                     reqValid,
    output logic                          reqReady,
    input  wire dpdpb_pkg::dpdpb_req_t    req,
    input  wire logic                     tagRetire,
    output logic                          outValid,
    input  wire logic                     outReady,
    output dpdpb_pkg::dpdpb_beat_t        outBeat
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dpdpb_pkg::dpdpb_state_t state_q;
    dpdpb_pkg::dpdpb_state_t state_d;
    dpdpb_pkg::dpdpb_state_t stateAfter;
    dpdpb_pkg::dpdpb_req_t   req_q;
    dpdpb_pkg::dpdpb_beat_t  beat_q;
    dpdpb_pkg::dpdpb_beat_t  beat_d;

    logic [1:0]   ctrl_q;
    logic [21:0]  scrOff_q;
    logic [3:0]   scrSize_q;
    logic [26:0]  bindPtr_q;
    logic [26:0]  samplerPtr_q;
    logic [23:0]  threadId_q;
    logic [9:0]   tagNext_q;
    logic [10:0]  outstanding_q;
    logic [10:0]  outstanding_d;
    logic         wEn_q;
    logic         primOmit_q;
    logic [31:0]  regRdData_q;

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire hitCtrl    = regAddr == dpdpb_pkg::REG_CTRL;
    wire hitScratch = regAddr == dpdpb_pkg::REG_SCRATCH;
    wire hitBind    = regAddr == dpdpb_pkg::REG_BIND;
    wire hitSampler = regAddr == dpdpb_pkg::REG_SAMPLER;
    wire hitStatus  = regAddr == dpdpb_pkg::REG_STATUS;
    wire hitTid     = regAddr == dpdpb_pkg::REG_THREADID;

    wire [3:0] wrSize  = regWrData[dpdpb_pkg::SCR_SIZE_W-1:0];
    // an out-of-range exponent is dropped so the header never carries it
    wire       sizeOk  = wrSize <= dpdpb_pkg::SCR_SIZE_MAX;
    wire       busy    = state_q != dpdpb_pkg::ST_IDLE;

    wire [31:0] rdMux =
        hitCtrl    ? {30'h0, ctrl_q} :
        hitScratch ? {scrOff_q, 6'h0, scrSize_q} :
        hitBind    ? {bindPtr_q, 5'h0} :
        hitSampler ? {samplerPtr_q, 5'h0} :
        hitStatus  ? {15'h0, busy, 5'h0, outstanding_q} :
        hitTid     ? {8'h0, threadId_q} :
                     32'h00000000;

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_q       <= dpdpb_pkg::CTRL_RESET;
            scrOff_q     <= dpdpb_pkg::SCR_OFF_RESET;
            scrSize_q    <= dpdpb_pkg::SCR_SIZE_RESET;
            bindPtr_q    <= dpdpb_pkg::PTR_RESET;
            samplerPtr_q <= dpdpb_pkg::PTR_RESET;
        end else if (regWrite) begin
            if (hitCtrl) begin
                ctrl_q <= regWrData[1:0];
            end
            if (hitScratch) begin
                scrOff_q <= regWrData[31:dpdpb_pkg::SCR_OFF_LSB];
            end
            if (hitScratch && sizeOk) begin
                scrSize_q <= wrSize;
            end
            if (hitBind) begin
                bindPtr_q <= regWrData[31:dpdpb_pkg::PTR_LSB];
            end
            if (hitSampler) begin
                samplerPtr_q <= regWrData[31:dpdpb_pkg::PTR_LSB];
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (reset) begin
            regRdData_q <= 32'h00000000;
        end else begin
            regRdData_q <= regRead ? rdMux : 32'h00000000;
        end
    end
    assign regRdData = regRdData_q;

    // ----------------------------------------------------------------
    // thread admission and identity
    // ----------------------------------------------------------------
    // tags are handed out in sequence; this assumes retirement in order
    wire tagFree = outstanding_q < dpdpb_pkg::TAG_LIMIT;
    assign reqReady = !busy && tagFree;
    wire accept  = reqValid && reqReady;
    wire advance = outValid && outReady;
    wire retire  = tagRetire && (outstanding_q != 11'h000);

    assign outstanding_d = outstanding_q + {10'h0, accept} - {10'h0, retire};

    always_ff @(posedge mclk) begin
        if (reset) begin
            threadId_q    <= 24'h000000;
            tagNext_q     <= 10'h000;
            outstanding_q <= 11'h000;
        end else begin
            outstanding_q <= outstanding_d;
            if (accept) begin
                threadId_q <= threadId_q + 24'h000001;
                tagNext_q  <= tagNext_q + 10'h001;
            end
        end
    end

    // thread inputs and mode flags are frozen for the whole payload
    always_ff @(posedge mclk) begin
        if (reset) begin
            req_q      <= '0;
            wEn_q      <= 1'b0;
            primOmit_q <= 1'b0;
        end else if (accept) begin
            req_q      <= req;
            wEn_q      <= ctrl_q[dpdpb_pkg::CTRL_WEN_BIT];
            primOmit_q <= ctrl_q[dpdpb_pkg::CTRL_OMIT_BIT];
        end
    end

    // ----------------------------------------------------------------
    // payload words
    // ----------------------------------------------------------------
    wire [31:0] hdrDw0 = {16'h0000, req.retBufOff0};
    wire [31:0] hdrDw1 = {16'h0000, req.retBufOff1};
    wire [31:0] hdrDw2 = 32'h00000000;
    wire [31:0] hdrDw3 = {samplerPtr_q, 1'b0, scrSize_q};
    wire [31:0] hdrDw4 = {bindPtr_q, 5'h00};
    wire [31:0] hdrDw5 = {scrOff_q, tagNext_q};
    wire [31:0] hdrDw6 = {8'h00, threadId_q};
    wire [31:0] hdrDw7 = 32'h00000000;
    wire [255:0] hdrWord = {hdrDw7, hdrDw6, hdrDw5, hdrDw4,
                            hdrDw3, hdrDw2, hdrDw1, hdrDw0};

    wire [255:0] primWord = {96'h0, req_q.primId1,
                             96'h0, req_q.primId0};
    wire [255:0] uWord = req_q.uCoord;
    wire [255:0] vWord = req_q.vCoord;

    logic [7:0][31:0] wCoord;
    logic [7:0][31:0] uvSum;

    // two adders per lane: U+V, then 1.0 minus that sum
    generate
        for (genvar lane = 0; lane < 8; lane++) begin : gLane
            logic [31:0] wLane;
            dpdpb_fp_add uAddV (
                .opA (req_q.uCoord[lane]),
                .opB (req_q.vCoord[lane]),
                .sum (uvSum[lane])
            );
            dpdpb_fp_add oneSub (
                .opA (dpdpb_pkg::FP_ONE),
                .opB ({~uvSum[lane][31], uvSum[lane][30:0]}),
                .sum (wLane)
            );
            assign wCoord[lane] = wEn_q ? wLane : dpdpb_pkg::FP_ZERO;
        end
    endgenerate
    wire [255:0] wWord = wCoord;

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_comb begin
        unique case (state_q)
            dpdpb_pkg::ST_IDLE: stateAfter = dpdpb_pkg::ST_IDLE;
            dpdpb_pkg::ST_HDR: begin
                stateAfter = primOmit_q ? dpdpb_pkg::ST_UCRD
                                        : dpdpb_pkg::ST_PRIM;
            end
            dpdpb_pkg::ST_PRIM: stateAfter = dpdpb_pkg::ST_UCRD;
            dpdpb_pkg::ST_UCRD: stateAfter = dpdpb_pkg::ST_VCRD;
            dpdpb_pkg::ST_VCRD: stateAfter = dpdpb_pkg::ST_WCRD;
            dpdpb_pkg::ST_WCRD: stateAfter = dpdpb_pkg::ST_IDLE;
            default:            stateAfter = dpdpb_pkg::ST_IDLE;
        endcase
    end

    always_comb begin
        if (accept) begin
            state_d = dpdpb_pkg::ST_HDR;
        end else if (advance) begin
            state_d = stateAfter;
        end else begin
            state_d = state_q;
        end
    end

    wire loadBeat = accept || advance;
    wire [255:0] nextWord =
        (state_d == dpdpb_pkg::ST_HDR)  ? hdrWord :
        (state_d == dpdpb_pkg::ST_PRIM) ? primWord :
        (state_d == dpdpb_pkg::ST_UCRD) ? uWord :
        (state_d == dpdpb_pkg::ST_VCRD) ? vWord :
        (state_d == dpdpb_pkg::ST_WCRD) ? wWord :
                                          256'h0;

    always_comb begin
        beat_d = beat_q;
        if (loadBeat) begin
            beat_d.first = state_d == dpdpb_pkg::ST_HDR;
            beat_d.last  = state_d == dpdpb_pkg::ST_WCRD;
            beat_d.data  = nextWord;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= dpdpb_pkg::ST_IDLE;
            beat_q  <= '0;
        end else begin
            state_q <= state_d;
            beat_q  <= beat_d;
        end
    end

    assign outValid = busy;
    assign outBeat  = beat_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_tidStep;
        @(posedge mclk) disable iff (reset)
        accept |=> threadId_q == $past(threadId_q) + 24'h000001;
    endproperty
    a_tidStep: assert property (p_tidStep)
        else $error("thread id did not step on accept");

    property p_hdrTag;
        @(posedge mclk) disable iff (reset)
        accept |=> outBeat.first && outBeat.data[169:160] == $past(tagNext_q)
                   && outBeat.data[223:216] == 8'h00;
    endproperty
    a_hdrTag: assert property (p_hdrTag)
        else $error("header tag or reserved id bits wrong");

    property p_hdrRetBuf;
        @(posedge mclk) disable iff (reset)
        accept |=> outBeat.data[15:0] == $past(req.retBufOff0)
                   && outBeat.data[47:32] == $past(req.retBufOff1)
                   && outBeat.data[31:16] == 16'h0000
                   && outBeat.data[63:48] == 16'h0000;
    endproperty
    a_hdrRetBuf: assert property (p_hdrRetBuf)
        else $error("header return buffer offsets wrong");

    property p_hdrDw2Zero;
        @(posedge mclk) disable iff (reset)
        outValid && outBeat.first |-> outBeat.data[95:64] == 32'h00000000;
    endproperty
    a_hdrDw2Zero: assert property (p_hdrDw2Zero)
        else $error("header dword 2 not zero");

    property p_scrSizeLegal;
        @(posedge mclk) disable iff (reset)
        regWrite && hitScratch && !sizeOk |=> scrSize_q == $past(scrSize_q);
    endproperty
    a_scrSizeLegal: assert property (p_scrSizeLegal)
        else $error("illegal scratch size accepted");

    property p_omitSkips;
        @(posedge mclk) disable iff (reset)
        advance && state_q == dpdpb_pkg::ST_HDR && primOmit_q
            |=> state_q == dpdpb_pkg::ST_UCRD && outBeat.data == req_q.uCoord;
    endproperty
    a_omitSkips: assert property (p_omitSkips)
        else $error("primitive id word not skipped");

    property p_primWord;
        @(posedge mclk) disable iff (reset)
        advance && state_q == dpdpb_pkg::ST_HDR && !primOmit_q
            |=> outBeat.data[159:128] == req_q.primId1
                && outBeat.data[31:0] == req_q.primId0
                && outBeat.data[255:160] == 96'h0;
    endproperty
    a_primWord: assert property (p_primWord)
        else $error("primitive id word malformed");

    property p_vFollowsU;
        @(posedge mclk) disable iff (reset)
        advance && state_q == dpdpb_pkg::ST_UCRD
            |=> state_q == dpdpb_pkg::ST_VCRD && outBeat.data == req_q.vCoord;
    endproperty
    a_vFollowsU: assert property (p_vFollowsU)
        else $error("V word not after U word");

    property p_wZero;
        @(posedge mclk) disable iff (reset)
        state_q == dpdpb_pkg::ST_WCRD && !wEn_q |-> outBeat.data == 256'h0 && outBeat.last;
    endproperty
    a_wZero: assert property (p_wZero)
        else $error("W word not zero with compute disabled");

    property p_holdStall;
        @(posedge mclk) disable iff (reset)
        outValid && !outReady |=> outValid && $stable(outBeat);
    endproperty
    a_holdStall: assert property (p_holdStall)
        else $error("beat changed while stalled");

endmodule

// >>> dpdpb_dispatch_model.sv
// dispatcher model: takes payload words, stalls on request, retires threads
`timescale 1ns/1ps
module dpdpb_dispatch_model (
    input  wire logic                   mclk,
    input  wire logic                   reset,
    input  wire logic                   slowMode,
    input  wire logic                   outValid,
    input  wire dpdpb_pkg::dpdpb_beat_t outBeat,
    output logic                        outReady,
    output logic                        tagRetire,
    input  wire logic                   retireLoad,
    input  wire logic [3:0]             retireNum
);
    dpdpb_pkg::dpdpb_beat_t beatQ[$];
    integer                 seed       = 32'hA04E;
    integer                 retireLeft = 0;

    // ----------------------------------------------------------------
    // accept words; slow mode drops ready at random to stall the builder
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (!reset && outValid && outReady) begin
            beatQ.push_back(outBeat);
        end
        outReady <= !reset && (!slowMode || $random(seed) % 2 != 0);
        // retires hold tagRetire high for back-to-back cycles, one cycle per requested thread
        tagRetire <= !reset && retireLeft > 0;
        if (retireLoad) begin
            retireLeft <= retireNum;
        end else if (retireLeft > 0) begin
            retireLeft <= retireLeft - 1;
        end
    end
endmodule

// >>> dpdpb_tb.sv
// self-checking testbench of the dual patch payload builder
`timescale 1ns/1ps
module testbench;
    logic                   mclk, reset, regWrite, regRead, reqValid, reqReady;
    logic                   tagRetire, outValid, outReady, slowMode;
    logic [7:0]             regAddr;
    logic [31:0]            regWrData, regRdData, scrVal, bindVal, smpVal;
    dpdpb_pkg::dpdpb_req_t  req, r;
    dpdpb_pkg::dpdpb_beat_t outBeat;
    logic [255:0]           hdr, prim, w;
    integer                 seed = 32'hA04E;
    integer                 mismatches = 0;
    integer                 totalChecks = 0;
    integer                 nU[8], nV[8];
    integer                 i, k, n, b;
    logic                   omit, wen, retireLoad;
    logic [3:0]             retireNum;

    dpdpb_builder dut_u (.mclk(mclk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .tagRetire(tagRetire), .outValid(outValid), .outReady(outReady), .outBeat(outBeat));
    dpdpb_dispatch_model disp_u (.mclk(mclk), .reset(reset), .slowMode(slowMode),
        .outValid(outValid), .outBeat(outBeat), .outReady(outReady), .tagRetire(tagRetire),
        .retireLoad(retireLoad), .retireNum(retireNum));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string what, input logic [257:0] got, input logic [257:0] exp);
        totalChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge mclk);
        regWrite  <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe edge
    task automatic regRd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        check("regread", regRdData, exp);
    endtask

    // value n/8 as single precision; exact, so truncation cannot bite
    function automatic logic [31:0] f8(input integer v);
        integer m, p;
        m = v < 0 ? -v : v;
        p = 0;
        for (int j = 0; j < 5; j++) if ((m >> j) != 0) p = j;
        if (m == 0) return 32'h0;
        return {v < 0, 8'(p + 124), 23'(m << (23 - p))};
    endfunction

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset = 1'b1; regAddr = 8'h0; regWrData = 32'h0; regWrite = 1'b0;
        regRead = 1'b0; reqValid = 1'b0; req = '0; slowMode = 1'b0;
        retireLoad = 1'b0;
        retireNum = 4'h0;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        for (k = 0; k < 7; k++) regRd(8'(k * 4), 32'h0); // reset values and unmapped
        scrVal  = {$random(seed)} & 32'hFFFFFC00;
        bindVal = $random(seed);
        smpVal  = $random(seed);
        regWr(dpdpb_pkg::REG_SCRATCH, scrVal | 32'h0000000B);
        regRd(dpdpb_pkg::REG_SCRATCH, scrVal | 32'h0000000B);
        scrVal  = {$random(seed)} & 32'hFFFFFC00;
        regWr(dpdpb_pkg::REG_SCRATCH, scrVal | 32'h0000000C);
        regRd(dpdpb_pkg::REG_SCRATCH, scrVal | 32'h0000000B);
        regWr(dpdpb_pkg::REG_BIND, bindVal);
        regWr(dpdpb_pkg::REG_SAMPLER, smpVal);
        regWr(dpdpb_pkg::REG_STATUS, 32'hFFFFFFFF);
        regWr(dpdpb_pkg::REG_THREADID, 32'hFFFFFFFF);
        regWr(8'h18, 32'hFFFFFFFF);
        regRd(dpdpb_pkg::REG_STATUS, 32'h0);
        regRd(dpdpb_pkg::REG_THREADID, 32'h0);
        regRd(8'h18, 32'h0);
        for (i = 0; i < 12; i++) begin
            wen  = i[0];
            omit = i[1];
            regWr(dpdpb_pkg::REG_CTRL, {30'h0, omit, wen});
            r = '0;
            r.retBufOff0 = (i == 3) ? 16'hFFFF : 16'($random(seed));
            r.retBufOff1 = 16'($random(seed));
            r.primId0 = $random(seed);
            r.primId1 = $random(seed);
            for (k = 0; k < 8; k++) begin
                nU[k] = {$random(seed)} % 9;
                nV[k] = {$random(seed)} % 9;
                r.uCoord[k] = f8(nU[k]);
                r.vCoord[k] = f8(nV[k]);
                w[k*32 +: 32] = wen ? f8(8 - nU[k] - nV[k]) : 32'h0;
            end
            hdr = {32'h0, 8'h0, 24'(i), scrVal[31:10], 10'(i), bindVal[31:5], 5'h0,
                   smpVal[31:5], 1'b0, 4'hB, 32'h0, 16'h0, r.retBufOff1, 16'h0, r.retBufOff0};
            prim = {96'h0, r.primId1, 96'h0, r.primId0};
            @(posedge mclk);
            slowMode <= (i >= 6);
            req      <= r;
            reqValid <= 1'b1;
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (reqReady !== 1'b1 && n < 100);
            reqValid <= 1'b0;
            if (reqReady !== 1'b1) begin
                mismatches++;
                conclude();
            end
            @(negedge mclk);
            check("busy", reqReady, 1'b0);
            for (n = 0; n < 300 && disp_u.beatQ.size() < (omit ? 4 : 5); n++) @(posedge mclk);
            repeat (3) @(posedge mclk);
            check("beats", disp_u.beatQ.size(), omit ? 4 : 5);
            if (disp_u.beatQ.size() < (omit ? 4 : 5)) begin
                mismatches++;
                conclude();
            end
            b = omit ? 1 : 2;
            check("header", disp_u.beatQ[0], {2'b10, hdr});
            if (!omit) check("primid", disp_u.beatQ[1], {2'b00, prim});
            check("ucoord", disp_u.beatQ[b], {2'b00, r.uCoord});
            check("vcoord", disp_u.beatQ[b+1], {2'b00, r.vCoord});
            check("wcoord", disp_u.beatQ[b+2], {2'b01, w});
            disp_u.beatQ.delete();
        end
        regRd(dpdpb_pkg::REG_STATUS, 32'h0000000C);
        @(posedge mclk);
        retireNum  <= 4'h3;
        retireLoad <= 1'b1;
        @(posedge mclk);
        retireLoad <= 1'b0;
        repeat (8) @(posedge mclk);
        regRd(dpdpb_pkg::REG_STATUS, 32'h00000009);
        regRd(dpdpb_pkg::REG_THREADID, 32'h0000000C);
        conclude();
    end
endmodule
